//--- design/mgpe_cfg.svh
`ifndef MGPE_CFG_SVH
`define MGPE_CFG_SVH
`define MGPE_EVT_W 7
`define MGPE_TGT_W 6
`define MGPE_BLK_W 4
`define MGPE_TGT_MEDIA 6'h03
`define MGPE_BLK_MEDIA 4'h6
`define MGPE_TGT_GASKET 6'h04
`define MGPE_BLK_GASKET 4'h7
`define MGPE_EV_TB_EMPTY0 7'h54
`define MGPE_EV_TB_EMPTY2 7'h56
`define MGPE_EV_DPUSH_TB 7'h58
`define MGPE_EV_SPULL0_TB 7'h59
`define MGPE_EV_SPULL1_TB 7'h5a
`define MGPE_EV_CSR_WR 7'h5b
`define MGPE_EV_DPULL_RB 7'h5c
`define MGPE_EV_SPUSH_RB 7'h5d
`define MGPE_EV_CSR_RD 7'h5e
`define MGPE_EV_CSR_FWR 7'h5f
`define MGPE_EV_AUTOPUSH 7'h60
`define MGPE_EV_NULL_AP 7'h61
`define MGPE_EV_TX_SKIP 7'h62
`define MGPE_EV_RDY_FIRST 7'h63
`define MGPE_EV_RDY_LAST 7'h66
`define MGPE_EV_FCI_ENQ 7'h67
`define MGPE_EV_FCI_DEQ 7'h68
`define MGPE_EV_FCI_ERR 7'h69
`define MGPE_EV_FCI_SYNC 7'h6a
`define MGPE_EV_VPAR 7'h6b
`define MGPE_EV_HPAR 7'h6c
`define MGPE_EV_DIP4 7'h6d
`define MGPE_EV_DIP2 7'h6e
`define MGPE_EV_RXACT_FIRST 7'h70
`define MGPE_EV_RXACT_LAST 7'h73
`define MGPE_EV_TXACT_FIRST 7'h74
`define MGPE_EV_TXACT_LAST 7'h76
`define MGPE_EV_FCE_TX 7'h77
`define MGPE_EV_FCI_RX 7'h78
`define MGPE_EV_RXFIFO_ERR 7'h79
`define MGPE_EV_LCSR_EVEN 7'h0a
`define MGPE_EV_LCSR_ODD 7'h0b
`define MGPE_EV_LCSR_OR 7'h0c
`define MGPE_EV_PQ_FIRST 7'h0d
`define MGPE_EV_PQ_LAST 7'h1b
`define MGPE_EV_EMPTY_FIRST 7'h22
`define MGPE_EV_EMPTY_LAST 7'h2b
`define MGPE_EV_OQ_FULL 7'h29
`define MGPE_EV_HASH48 7'h2c
`define MGPE_EV_HASH128 7'h2e
`define MGPE_EV_FAST_INT 7'h2f
`define MGPE_EV_NORM_INT 7'h30
`define MGPE_NUM_PQ 5
`define MGPE_NUM_EMPTY 10
`define MGPE_PQ_STRIDE 7'h03
`define MGPE_EMPTY_RSV 7'h05
`endif

//--- design/mgpe_pkg.sv
package mgpe_pkg;
  typedef enum logic [1:0] {
    MGPE_RX_CSIX,
    MGPE_RX_SPI4,
    MGPE_RX_OFF
  } mgpe_rxmode_type;
  typedef struct packed {
    logic [1:0] sync_reg;
  } mgpe_sync_type;
  typedef struct packed {
    logic [2:0] sync_reg;
    logic pulse_reg;
  } mgpe_pcross_type;
endpackage : mgpe_pkg

//--- design/mgpe_level_sync.sv
`timescale 1ns/10ps
`default_nettype none
// Two-stage synchroniser for a level from another clock domain
module mgpe_level_sync
  import mgpe_pkg::*;
(
  input wire logic i_ref_clk, // core clock
  input wire logic i_reset, // sync reset
  input wire logic i_level, // foreign-domain level
  output logic o_level // synchronised level
);
  mgpe_sync_type st_reg;
  mgpe_sync_type st_next;
  always_comb begin
    st_next = st_reg;
    st_next.sync_reg = {st_reg.sync_reg[0], i_level};
    if (i_reset) begin
      st_next.sync_reg = 2'h0;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    st_reg <= st_next;
  end
  assign o_level = st_reg.sync_reg[1];
endmodule : mgpe_level_sync
`default_nettype wire

//--- design/mgpe_pulse_cross.sv
`timescale 1ns/10ps
`default_nettype none
// Toggle from the foreign domain becomes a one-cycle core pulse
module mgpe_pulse_cross
  import mgpe_pkg::*;
(
  input wire logic i_ref_clk, // core clock
  input wire logic i_reset, // sync reset
  input wire logic i_toggle, // flips once per foreign event
  output logic o_pulse // one-cycle core pulse
);
  mgpe_pcross_type st_reg;
  mgpe_pcross_type st_next;
  always_comb begin
    st_next = st_reg;
    st_next.sync_reg = {st_reg.sync_reg[1:0], i_toggle};
    // Edge taken between stages two and three; stage one stays private
    st_next.pulse_reg = st_reg.sync_reg[2] ^ st_reg.sync_reg[1];
    if (i_reset) begin
      // Stages keep sampling, so a toggle left high gives no false pulse
      st_next.pulse_reg = 1'b0;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    st_reg <= st_next;
  end
  assign o_pulse = st_reg.pulse_reg;
endmodule : mgpe_pulse_cross
`default_nettype wire

//--- design/mgpe_event_sel.sv
`timescale 1ns/10ps
`default_nettype none
`include "mgpe_cfg.svh"
// Functional notes
// - One pulse per quadword pushed from DRAM into the transmit buffer.
// - One pulse per longword from each SRAM pull path into transmit buffer.
// - One pulse per quadword pulled from receive buffer toward DRAM.
// - One pulse per longword pushed from receive buffer toward SRAM.
// - Transmit partition empty levels high while partition holds nothing.
// - Pulse on every receive autopush; separate pulse only for null ones.
// - Pulse when a transmit mpacket is dropped by its skip flag.
// - Four frame-ready levels shown only in CSIX receive mode.
// - Ingress queue error pulse on bad control frame, CSIX transmit only.
// - Pulse when ingress logic finds the ingress queue full on enqueue.
// - Parity pulses CSIX receive only; DIP pulses SPI-4 receive only.
// - Receive-active levels synchronised from media receive clock.
// - Transmit-active levels synchronised from media transmit clock.
// - Flow transmit-active level synchronised from its transmit clock.
// - Flow receive-active level synchronised from its receive clock.
// - Receive FIFO error toggle becomes one core pulse.
// - Gasket group selected by target 000100 and block 0111.
// - Return-data queue even, odd and either dequeue pulses.
// - Five push queues each give even, odd, either dequeue triples.
// - Command, data, pull empty flags and outbound queue full shown.
// - Separate pulses for 48, 64 and 128-bit hash commands.
// - Distinct pulses for fast and normal interrupts.
// - Media group selected by target 000011 and block 0110.
module mgpe_event_sel
  import mgpe_pkg::*;
(
  input wire logic i_ref_clk, // core clock, 40 MHz
  input wire logic i_reset, // sync reset, active high
  input wire logic [5:0] i_target_id, // monitor target select
  input wire logic [3:0] i_block_id, // monitor block select
  input wire logic [6:0] i_media_evt, // media event number
  input wire logic [6:0] i_gasket_evt, // gasket event number
  input wire logic i_csix_rx_mode, // receive side in CSIX mode
  input wire logic i_spi4_rx_mode, // receive side in SPI-4 mode
  input wire logic i_csix_tx_mode, // transmit side in CSIX mode
  input wire logic [2:0] i_tb_part_empty, // transmit partitions empty
  input wire logic i_dpush_tb_wr, // quadword written into transmit buffer
  input wire logic [1:0] i_spull_tb_wr, // longword from pull path 0/1
  input wire logic i_csr_wr, // register write strobe
  input wire logic i_dpull_rb_rd, // quadword read toward DRAM
  input wire logic i_spush_rb_rd, // longword read toward SRAM
  input wire logic i_csr_rd, // register read strobe
  input wire logic i_csr_fast_wr, // fast register write strobe
  input wire logic i_autopush, // receive autopush strobe
  input wire logic i_autopush_null, // that autopush is null
  input wire logic i_tx_skip, // mpacket dropped by skip flag
  input wire logic i_fabric_control_frame_ready, // fabric takes control
  input wire logic i_fabric_data_frame_ready, // fabric takes data
  input wire logic i_egress_control_frame_ready, // egress takes control
  input wire logic i_egress_data_frame_ready, // egress takes data
  input wire logic i_fci_enq, // ingress queue enqueue
  input wire logic i_fci_deq, // ingress queue dequeue
  input wire logic i_control_side_bus_vpar_err, // control bus vertical parity
  input wire logic i_control_side_bus_hpar_err, // control bus horizontal parity
  input wire logic i_control_side_bus_early_sof, // premature frame start
  input wire logic i_fci_enq_try, // ingress logic tries enqueue
  input wire logic i_fci_full, // ingress queue full
  input wire logic i_rx_vpar_err, // receive vertical parity
  input wire logic i_rx_hpar_err, // receive horizontal parity
  input wire logic i_rx_dip4_err, // receive DIP-4 error
  input wire logic i_rx_dip2_err, // receive DIP-2 error
  input wire logic [3:0] i_rx_active_mr, // rx active, media rx domain
  input wire logic [2:0] i_tx_valid_mt, // tx valid, media tx domain
  input wire logic i_fce_tx_valid, // flow tx valid, own domain
  input wire logic i_fci_rx_valid, // flow rx valid, own domain
  input wire logic i_rxfifo_err_tgl, // rx FIFO error toggle, rx domain
  input wire logic [1:0] i_lcsr_deq, // return queue even/odd dequeue
  input wire logic [9:0] i_pq_deq, // push queues {odd,even} per queue
  input wire logic [9:0] i_queue_empty, // empty/full flags, events 34-43
  input wire logic [2:0] i_hash_cmd, // 48/64/128-bit hash command
  input wire logic i_fast_int, // fast interrupt raised
  input wire logic i_norm_int, // normal interrupt raised
  output logic o_media_event, // selected media event
  output logic o_gasket_event // selected gasket event
);
  typedef struct packed {
    logic media_reg;
    logic gasket_reg;
  } mgpe_sel_type;
  mgpe_sel_type st_reg;
  mgpe_sel_type st_next;
  logic [3:0] rx_act;
  logic [2:0] tx_act;
  logic fce_tx_act;
  logic fci_rx_act;
  logic rxfifo_err;
  logic media_grp;
  logic gasket_grp;
  logic media_src;
  logic gasket_src;
  logic [6:0] pq_off;
  logic [6:0] em_off;
  logic [2:0] pq_idx;

  // Foreign-domain levels; the counts they feed are approximate
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_rx
      mgpe_level_sync u_rx (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_level(i_rx_active_mr[gi]),
        .o_level(rx_act[gi])
      );
    end
    for (gi = 0; gi < 3; gi++) begin : g_tx
      mgpe_level_sync u_tx (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_level(i_tx_valid_mt[gi]),
        .o_level(tx_act[gi])
      );
    end
  endgenerate
  mgpe_level_sync u_fce_tx (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_level(i_fce_tx_valid),
    .o_level(fce_tx_act)
  );
  mgpe_level_sync u_fci_rx (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_level(i_fci_rx_valid),
    .o_level(fci_rx_act)
  );
  mgpe_pulse_cross u_rxerr (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_toggle(i_rxfifo_err_tgl),
    .o_pulse(rxfifo_err)
  );

  assign media_grp = (i_target_id == `MGPE_TGT_MEDIA) &&
                     (i_block_id == `MGPE_BLK_MEDIA);
  assign gasket_grp = (i_target_id == `MGPE_TGT_GASKET) &&
                      (i_block_id == `MGPE_BLK_GASKET);

  always_comb begin
    media_src = 1'b0;
    if (i_media_evt >= `MGPE_EV_TB_EMPTY0 &&
        i_media_evt <= `MGPE_EV_TB_EMPTY2) begin
      media_src = i_tb_part_empty[2'(i_media_evt - `MGPE_EV_TB_EMPTY0)];
    end else if (i_media_evt >= `MGPE_EV_RDY_FIRST &&
                 i_media_evt <= `MGPE_EV_RDY_LAST) begin
      case (2'(i_media_evt - `MGPE_EV_RDY_FIRST))
        2'h0: media_src = i_fabric_control_frame_ready;
        2'h1: media_src = i_fabric_data_frame_ready;
        2'h2: media_src = i_egress_control_frame_ready;
        default: media_src = i_egress_data_frame_ready;
      endcase
      media_src = media_src & i_csix_rx_mode;
    end else if (i_media_evt >= `MGPE_EV_RXACT_FIRST &&
                 i_media_evt <= `MGPE_EV_RXACT_LAST) begin
      media_src = rx_act[2'(i_media_evt - `MGPE_EV_RXACT_FIRST)];
    end else if (i_media_evt >= `MGPE_EV_TXACT_FIRST &&
                 i_media_evt <= `MGPE_EV_TXACT_LAST) begin
      media_src = tx_act[2'(i_media_evt - `MGPE_EV_TXACT_FIRST)];
    end else begin
      case (i_media_evt)
        `MGPE_EV_DPUSH_TB: media_src = i_dpush_tb_wr;
        `MGPE_EV_SPULL0_TB: media_src = i_spull_tb_wr[0];
        `MGPE_EV_SPULL1_TB: media_src = i_spull_tb_wr[1];
        `MGPE_EV_CSR_WR: media_src = i_csr_wr;
        `MGPE_EV_DPULL_RB: media_src = i_dpull_rb_rd;
        `MGPE_EV_SPUSH_RB: media_src = i_spush_rb_rd;
        `MGPE_EV_CSR_RD: media_src = i_csr_rd;
        `MGPE_EV_CSR_FWR: media_src = i_csr_fast_wr;
        `MGPE_EV_AUTOPUSH: media_src = i_autopush;
        `MGPE_EV_NULL_AP: media_src = i_autopush & i_autopush_null;
        `MGPE_EV_TX_SKIP: media_src = i_tx_skip;
        `MGPE_EV_FCI_ENQ: media_src = i_fci_enq;
        `MGPE_EV_FCI_DEQ: media_src = i_fci_deq;
        `MGPE_EV_FCI_ERR: media_src = i_csix_tx_mode &
          (i_control_side_bus_vpar_err | i_control_side_bus_hpar_err | i_control_side_bus_early_sof);
        `MGPE_EV_FCI_SYNC: media_src = i_fci_enq_try & i_fci_full;
        `MGPE_EV_VPAR: media_src = i_rx_vpar_err & i_csix_rx_mode;
        `MGPE_EV_HPAR: media_src = i_rx_hpar_err & i_csix_rx_mode;
        `MGPE_EV_DIP4: media_src = i_rx_dip4_err & i_spi4_rx_mode;
        `MGPE_EV_DIP2: media_src = i_rx_dip2_err & i_spi4_rx_mode;
        `MGPE_EV_FCE_TX: media_src = fce_tx_act;
        `MGPE_EV_FCI_RX: media_src = fci_rx_act;
        `MGPE_EV_RXFIFO_ERR: media_src = rxfifo_err;
        default: media_src = 1'b0;
      endcase
    end
  end

  // Push queues sit in triples starting at their first event number
  assign pq_off = i_gasket_evt - `MGPE_EV_PQ_FIRST;
  assign em_off = i_gasket_evt - `MGPE_EV_EMPTY_FIRST;
  assign pq_idx = 3'(pq_off / `MGPE_PQ_STRIDE);

  always_comb begin
    gasket_src = 1'b0;
    if (i_gasket_evt >= `MGPE_EV_PQ_FIRST &&
        i_gasket_evt <= `MGPE_EV_PQ_LAST) begin
      case (2'(pq_off % `MGPE_PQ_STRIDE))
        2'h0: gasket_src = i_pq_deq[{pq_idx, 1'b0}];
        2'h1: gasket_src = i_pq_deq[{pq_idx, 1'b1}];
        default: gasket_src = |i_pq_deq[{pq_idx, 1'b0} +: 2];
      endcase
    end else if (i_gasket_evt >= `MGPE_EV_EMPTY_FIRST &&
                 i_gasket_evt <= `MGPE_EV_EMPTY_LAST) begin
      // Slot 39 is reserved and reads low
      gasket_src = (em_off == `MGPE_EMPTY_RSV) ? 1'b0 :
                   i_queue_empty[4'(em_off)];
    end else if (i_gasket_evt >= `MGPE_EV_HASH48 &&
                 i_gasket_evt <= `MGPE_EV_HASH128) begin
      gasket_src = i_hash_cmd[2'(i_gasket_evt - `MGPE_EV_HASH48)];
    end else begin
      case (i_gasket_evt)
        `MGPE_EV_LCSR_EVEN: gasket_src = i_lcsr_deq[0];
        `MGPE_EV_LCSR_ODD: gasket_src = i_lcsr_deq[1];
        `MGPE_EV_LCSR_OR: gasket_src = |i_lcsr_deq;
        `MGPE_EV_FAST_INT: gasket_src = i_fast_int;
        `MGPE_EV_NORM_INT: gasket_src = i_norm_int;
        default: gasket_src = 1'b0;
      endcase
    end
  end

  always_comb begin
    st_next.media_reg = media_grp & media_src;
    st_next.gasket_reg = gasket_grp & gasket_src;
    if (i_reset) begin
      st_next = '0;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    st_reg <= st_next;
  end
  assign o_media_event = st_reg.media_reg;
  assign o_gasket_event = st_reg.gasket_reg;

  AST_DPUSH: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    media_grp && i_media_evt == `MGPE_EV_DPUSH_TB |=> o_media_event == $past(i_dpush_tb_wr))
    else $error("dpush event mismatch");
  AST_SPULL1: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    media_grp && i_media_evt == `MGPE_EV_SPULL1_TB && i_spull_tb_wr[1] |=> o_media_event)
    else $error("spull1 event missed");
  AST_DPULL: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    media_grp && i_media_evt == `MGPE_EV_DPULL_RB && i_dpull_rb_rd |=> o_media_event)
    else $error("dpull event missed");
  AST_TB_EMPTY: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    media_grp && i_media_evt == `MGPE_EV_TB_EMPTY2 |=> o_media_event == $past(i_tb_part_empty[2]))
    else $error("partition empty mismatch");
  AST_NULL_AP: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_media_evt == `MGPE_EV_NULL_AP && !i_autopush_null |=> !o_media_event)
    else $error("null autopush falsely counted");
  AST_RDY_MODE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_media_evt == `MGPE_EV_RDY_FIRST && !i_csix_rx_mode |=> !o_media_event)
    else $error("ready level outside CSIX rx");
  AST_DIP_MODE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_media_evt == `MGPE_EV_DIP4 && !i_spi4_rx_mode |=> !o_media_event)
    else $error("DIP error outside SPI-4 rx");
  AST_RXERR: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    media_grp && i_media_evt == `MGPE_EV_RXFIFO_ERR && $changed(i_rxfifo_err_tgl)
    ##1 (media_grp && i_media_evt == `MGPE_EV_RXFIFO_ERR)[*3] |=> o_media_event)
    else $error("rx fifo error not crossed");
  AST_RESERVED: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_media_evt == 7'h7a |=> !o_media_event)
    else $error("reserved event not low");
  AST_GRP_GATE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    !gasket_grp |=> !o_gasket_event)
    else $error("gasket event outside its group");
  AST_PQ_OR: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    gasket_grp && i_gasket_evt == `MGPE_EV_PQ_LAST && i_pq_deq[8] |=> o_gasket_event)
    else $error("push queue 4 either missed");
  AST_FAST_INT: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    gasket_grp && i_gasket_evt == `MGPE_EV_FAST_INT |=> o_gasket_event == $past(i_fast_int))
    else $error("fast interrupt mismatch");
  AST_SPUSH: assert property (@(posedge i_ref_clk)
    disable iff (i_reset) media_grp && i_media_evt == `MGPE_EV_SPUSH_RB &&
    i_spush_rb_rd |=> o_media_event)
    else $error("spush event missed");
  AST_TX_SKIP: assert property (@(posedge i_ref_clk)
    disable iff (i_reset) media_grp && i_media_evt == `MGPE_EV_TX_SKIP |=>
    o_media_event == $past(i_tx_skip))
    else $error("tx skip mismatch");
  AST_FCI_ERR_MODE: assert property (@(posedge i_ref_clk)
    disable iff (i_reset) i_media_evt == `MGPE_EV_FCI_ERR &&
    !i_csix_tx_mode |=> !o_media_event)
    else $error("ingress error outside CSIX tx");
  AST_FCI_SYNC: assert property (@(posedge i_ref_clk)
    disable iff (i_reset) media_grp && i_media_evt == `MGPE_EV_FCI_SYNC |=>
    o_media_event == $past(i_fci_enq_try && i_fci_full))
    else $error("ingress full error mismatch");
  AST_MEDIA_GATE: assert property (@(posedge i_ref_clk)
    disable iff (i_reset) !media_grp |=> !o_media_event)
    else $error("media event outside its group");
  AST_LCSR_OR: assert property (@(posedge i_ref_clk)
    disable iff (i_reset) gasket_grp && i_gasket_evt == `MGPE_EV_LCSR_OR |=>
    o_gasket_event == $past(|i_lcsr_deq))
    else $error("return queue either mismatch");
  AST_OQ_FULL: assert property (@(posedge i_ref_clk)
    disable iff (i_reset) gasket_grp && i_gasket_evt == `MGPE_EV_OQ_FULL |=>
    o_gasket_event ==
    $past(i_queue_empty[4'(`MGPE_EV_OQ_FULL - `MGPE_EV_EMPTY_FIRST)]))
    else $error("outbound full flag mismatch");
  AST_HASH128: assert property (@(posedge i_ref_clk)
    disable iff (i_reset) gasket_grp && i_gasket_evt == `MGPE_EV_HASH128 |=>
    o_gasket_event == $past(i_hash_cmd[2]))
    else $error("hash 128 mismatch");
  COV_TX_SKIP: cover property (@(posedge i_ref_clk)
    i_media_evt == `MGPE_EV_TX_SKIP && i_tx_skip ##1 o_media_event);
  COV_RXACT: cover property (@(posedge i_ref_clk) o_media_event && i_media_evt == `MGPE_EV_RXACT_FIRST);
  COV_HASH: cover property (@(posedge i_ref_clk) o_gasket_event && i_gasket_evt == `MGPE_EV_HASH128);
  COV_NULL_AP: cover property (@(posedge i_ref_clk)
    o_media_event && i_media_evt == `MGPE_EV_NULL_AP);
endmodule : mgpe_event_sel
`default_nettype wire

//--- verif/mgpe_perf_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// Monitor side: one counter per event group, adding one per high cycle
module mgpe_perf_monitor
  import mgpe_pkg::*;
(
  input wire logic i_ref_clk, // core clock
  input wire logic i_reset, // sync reset
  input wire logic i_media_event, // selected media event
  input wire logic i_gasket_event, // selected gasket event
  output logic [15:0] o_media_count, // media high cycles
  output logic [15:0] o_gasket_count // gasket high cycles
);
  logic [15:0] media_count_reg;
  logic [15:0] gasket_count_reg;
  // A level adds its duration, a pulse adds exactly one
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      media_count_reg <= 16'h0000;
      gasket_count_reg <= 16'h0000;
    end else begin
      media_count_reg <= media_count_reg + {15'h0000, i_media_event};
      gasket_count_reg <= gasket_count_reg + {15'h0000, i_gasket_event};
    end
  end
  assign o_media_count = media_count_reg;
  assign o_gasket_count = gasket_count_reg;
endmodule : mgpe_perf_monitor
`default_nettype wire

//--- verif/media_gasket_perf_event_sources_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "mgpe_cfg.svh"
module media_gasket_perf_event_sources_tb_top;
  import mgpe_pkg::*;
  typedef struct packed {
    logic g;
    logic x;
    logic [6:0] evt;
    logic [6:0] a;
    logic [6:0] b;
    logic [2:0] mode;
    logic [2:0] lat;
    logic exp;
  } mgpe_row_type;
  localparam int N = 127;
  localparam int C = 4;
  localparam int S = 2;
  localparam int T = 1;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [5:0] target_id = 6'h00;
  logic [3:0] block_id = 4'h0;
  logic [6:0] media_evt = 7'h00;
  logic [6:0] gasket_evt = 7'h00;
  logic [2:0] mode = 3'h0;
  logic [65:0] src = '0;
  logic media_event;
  logic gasket_event;
  logic [15:0] media_count;
  logic [15:0] gasket_count;
  int bad_count = 0;
  int num_checks = 0;
  int exp_media = 0;
  int exp_gasket = 0;
  mgpe_row_type rows[$];
  localparam logic [6:0] RSV [10] = '{7'h57, 7'h6f, 7'h7a, 7'h7f, 7'h54,
                                      7'h1d, 7'h21, 7'h27, 7'h7d, 7'h0c};

  always #12.5 ref_clk = ~ref_clk;

  mgpe_event_sel i_dut (
    .i_ref_clk(ref_clk), .i_reset(reset), .i_target_id(target_id),
    .i_block_id(block_id), .i_media_evt(media_evt),
    .i_gasket_evt(gasket_evt), .i_csix_rx_mode(mode[2]),
    .i_spi4_rx_mode(mode[1]), .i_csix_tx_mode(mode[0]),
    .i_tb_part_empty(src[28:26]), .i_dpush_tb_wr(src[0]),
    .i_spull_tb_wr(src[2:1]), .i_csr_wr(src[3]), .i_dpull_rb_rd(src[4]),
    .i_spush_rb_rd(src[5]), .i_csr_rd(src[6]), .i_csr_fast_wr(src[7]),
    .i_autopush(src[8]), .i_autopush_null(src[9]), .i_tx_skip(src[10]),
    .i_fabric_control_frame_ready(src[11]),
    .i_fabric_data_frame_ready(src[12]),
    .i_egress_control_frame_ready(src[13]),
    .i_egress_data_frame_ready(src[14]), .i_fci_enq(src[15]),
    .i_fci_deq(src[16]), .i_control_side_bus_vpar_err(src[17]),
    .i_control_side_bus_hpar_err(src[18]), .i_control_side_bus_early_sof(src[19]),
    .i_fci_enq_try(src[20]), .i_fci_full(src[21]),
    .i_rx_vpar_err(src[22]), .i_rx_hpar_err(src[23]),
    .i_rx_dip4_err(src[24]), .i_rx_dip2_err(src[25]),
    .i_rx_active_mr(src[32:29]), .i_tx_valid_mt(src[35:33]),
    .i_fce_tx_valid(src[36]), .i_fci_rx_valid(src[37]),
    .i_rxfifo_err_tgl(src[38]), .i_lcsr_deq(src[40:39]),
    .i_pq_deq(src[50:41]), .i_queue_empty(src[60:51]),
    .i_hash_cmd(src[63:61]), .i_fast_int(src[64]), .i_norm_int(src[65]),
    .o_media_event(media_event), .o_gasket_event(gasket_event)
  );

  mgpe_perf_monitor i_monitor (
    .i_ref_clk(ref_clk), .i_reset(reset), .i_media_event(media_event),
    .i_gasket_event(gasket_event), .o_media_count(media_count),
    .o_gasket_count(gasket_count)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic row(input int g, input int evt, input int a, input int b,
                     input int m, input int l, input int e, input int x = 0);
    rows.push_back('{g[0], x[0], evt[6:0], a[6:0], b[6:0], m[2:0], l[2:0],
                     e[0]});
    if (e != 0 && g == 0) exp_media++;
    if (e != 0 && g != 0) exp_gasket++;
  endtask : row

  // Wrong pairing x crosses block to the other group's value; target stays
  task automatic sel(input logic g, input logic x, input logic [6:0] evt,
                     input logic [2:0] m);
    target_id <= g ? `MGPE_TGT_GASKET : `MGPE_TGT_MEDIA;
    block_id <= (g ^ x) ? `MGPE_BLK_GASKET : `MGPE_BLK_MEDIA;
    media_evt <= evt;
    gasket_evt <= evt;
    mode <= m;
  endtask : sel

  task automatic run_row(input mgpe_row_type r);
    string what;
    what = $sformatf("%s event %0d", r.g ? "gasket" : "media", r.evt);
    @(posedge ref_clk);
    sel(r.g, r.x, r.evt, r.mode);
    repeat (2) @(posedge ref_clk);
    src[r.a] <= 1'b1;
    if (r.b != 7'h7f) src[r.b] <= 1'b1;
    @(posedge ref_clk);
    // The error toggle stays put: dropping it would be a second error
    if (r.lat != 3'h4) begin
      src[r.a] <= 1'b0;
      if (r.b != 7'h7f) src[r.b] <= 1'b0;
    end
    repeat (r.lat - 1) @(posedge ref_clk);
    #1;
    check(16'(r.g ? gasket_event : media_event), 16'(r.exp), what);
    @(posedge ref_clk);
    #1;
    check(16'(r.g ? gasket_event : media_event), 16'h0000, what);
  endtask : run_row

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (3000) @(posedge ref_clk);
    bad_count++;
    print_verdict();
  end

  initial begin
    row(0,84,26,N,0,1,1); row(0,85,27,N,0,1,1); row(0,86,28,N,0,1,1);
    row(0,88,0,N,0,1,1);
    row(0,89,1,N,0,1,1); row(0,90,2,N,0,1,1);
    row(0,91,3,N,0,1,1); row(0,94,6,N,0,1,1); row(0,95,7,N,0,1,1);
    row(0,103,15,N,0,1,1); row(0,104,16,N,0,1,1);
    row(0,92,4,N,0,1,1);
    row(0,93,5,N,0,1,1);
    row(0,96,8,N,0,1,1); row(0,96,8,9,0,1,1); row(0,97,8,9,0,1,1);
    row(0,97,8,N,0,1,0); row(0,97,9,N,0,1,0);
    row(0,98,10,N,0,1,1);
    row(0,99,11,N,C,1,1); row(0,100,12,N,C,1,1); row(0,101,13,N,C,1,1);
    row(0,102,14,N,C,1,1); row(0,99,11,N,S,1,0); row(0,102,14,N,T,1,0);
    row(0,105,17,N,T,1,1); row(0,105,18,N,T,1,1); row(0,105,19,N,T,1,1);
    row(0,105,17,N,C,1,0);
    row(0,106,20,21,0,1,1); row(0,106,20,N,0,1,0); row(0,106,21,N,0,1,0);
    row(0,107,22,N,C,1,1); row(0,108,23,N,C,1,1); row(0,107,22,N,S,1,0);
    row(0,109,24,N,S,1,1); row(0,110,25,N,S,1,1); row(0,109,24,N,C,1,0);
    row(0,110,25,N,C,1,0); row(0,108,23,N,S,1,0);
    row(0,112,29,N,0,3,1); row(0,113,30,N,0,3,1); row(0,114,31,N,0,3,1);
    row(0,115,32,N,0,3,1);
    row(0,116,33,N,0,3,1); row(0,117,34,N,0,3,1); row(0,118,35,N,0,3,1);
    row(0,119,36,N,0,3,1);
    row(0,120,37,N,0,3,1);
    row(0,121,38,N,0,4,1);
    row(0,88,0,N,0,1,0,1);
    row(1,47,64,N,0,1,0,1);
    row(1,10,39,N,0,1,1); row(1,11,40,N,0,1,1); row(1,12,39,N,0,1,1);
    row(1,12,40,N,0,1,1); row(1,10,40,N,0,1,0);
    row(1,13,41,N,0,1,1); row(1,14,42,N,0,1,1); row(1,15,42,N,0,1,1);
    row(1,19,45,N,0,1,1); row(1,25,49,N,0,1,1); row(1,27,50,N,0,1,1);
    row(1,26,49,N,0,1,0); row(1,27,49,N,0,1,1);
    row(1,34,51,N,0,1,1); row(1,41,58,N,0,1,1); row(1,43,60,N,0,1,1);
    row(1,39,56,N,0,1,0);
    row(1,44,61,N,0,1,1); row(1,45,62,N,0,1,1); row(1,46,63,N,0,1,1);
    row(1,47,64,N,0,1,1); row(1,48,65,N,0,1,1); row(1,47,65,N,0,1,0);
    repeat (4) @(posedge ref_clk);
    #1;
    check(16'({media_event, gasket_event}), 16'h0000, "reset outputs");
    @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    #1;
    check(16'({media_event, gasket_event}), 16'h0000, "after release");
    foreach (rows[i]) run_row(rows[i]);
    repeat (2) @(posedge ref_clk);
    #1;
    check(media_count, 16'(exp_media), "media count");
    check(gasket_count, 16'(exp_gasket), "gasket count");
    $display("event table test done");
    // Every source high: only a real event number may show a one
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      src <= '1;
      sel(i >= 5, 1'b0, RSV[i], 3'h7);
      repeat (2) @(posedge ref_clk);
      #1;
      check(16'(i >= 5 ? gasket_event : media_event), 16'(i == 4 || i == 9),
            "reserved number");
    end
    $display("reserved number test done");
    @(posedge ref_clk);
    src <= 66'h000_0400_0000;
    sel(1'b0, 1'b0, 7'h54, 3'h0);
    repeat (3) @(posedge ref_clk);
    #1;
    check(16'(media_event), 16'h0001, "partition empty");
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    check(16'(media_event), 16'h0000, "during reset");
    @(posedge ref_clk);
    reset <= 1'b0;
    #1;
    check(16'(media_event), 16'h0000, "first edge after reset");
    @(posedge ref_clk);
    #1;
    check(16'(media_event), 16'h0001, "level after reset");
    $display("mid-run reset test done");
    print_verdict();
  end
endmodule : media_gasket_perf_event_sources_tb_top
`default_nettype wire
